// [eiv_pkg.sv]
// Purpose: constants and types for the pin request and vector block
// Assumes: 8-bit register port, 50 MHz system clock
// Notes: vector table bytes sit at the top 64 register addresses
//
// Behaviour
// - pin raises requests only while pin_function_enable is 1
// - synchronous logic samples the pin, edge-only or edge-and-level
// - in stop mode an enabled asserted pin wakes through async path
// - pullup on when enabled and pull_device_disable is 0, off at 1
// - pin event always sets flag; requests only if int enable set
// - flag sets on a deasserted-to-asserted pin transition
// - edge-and-level mode keeps flag set while the pin stays low
// - pin level is offered to branch_if_pin_high/low when enabled
// - sources other than the opcode, address and por resets forward a request only when their enable is 1
// - with mask clear: finish op, push five bytes, set mask, fetch
// - 32 two-byte vector entries, entry 0 on top, high byte first
// - lowest pending vector number wins
// - vector 0 is shared by all six reset sources
// - mode 0 falling edges only; mode 1 also while pin low
// - writing 1 to the ack bit clears the flag; ack reads 0
// - global mask is set after any reset
package eiv_pkg;
    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] EIV_ADDR_CTRL = 8'h00;
    localparam logic [7:0] EIV_ADDR_GMASK = 8'h01;
    localparam logic [7:0] EIV_ADDR_PEND = 8'h02;
    localparam logic [7:0] EIV_ADDR_ISTAT = 8'h04;
    localparam logic [7:0] EIV_ADDR_IMASK = 8'h05;
    localparam logic [7:0] EIV_ADDR_VEC_BASE = 8'hC0;
    // ***************************************************
    // control register fields
    // ***************************************************
    localparam int EIV_BIT_MODE = 0;
    localparam int EIV_BIT_IE = 1;
    localparam int EIV_BIT_ACK = 2;
    localparam int EIV_BIT_FLAG = 3;
    localparam int EIV_BIT_PE = 4;
    localparam int EIV_BIT_PDD = 6;
    // interrupt status bits
    localparam int EIV_IST_PIN = 0;
    localparam int EIV_IST_WAKE = 1;
    localparam int EIV_IST_TAKEN = 2;
    localparam int EIV_IST_W = 3;
    // ***************************************************
    // vectors
    // ***************************************************
    localparam int EIV_NVEC = 32;
    localparam logic [4:0] EIV_VEC_RESET = 5'h00;
    localparam logic [4:0] EIV_VEC_PIN = 5'h02;
    localparam logic [31:0] EIV_VEC_USED = 32'h009F_F0EF;
    localparam logic [15:0] EIV_VEC_TOP = 16'hFFFE;
    localparam logic [2:0] EIV_PUSH_LAST = 3'h4;
    // reset values
    localparam logic EIV_RST_GMASK = 1'b1;
    localparam logic EIV_RST_PIN_PREV = 1'b1;
    typedef enum logic [1:0] {
        EIV_IDLE = 2'b00,
        EIV_PUSH = 2'b01,
        EIV_FETCH = 2'b10
    } eiv_seq_e;
endpackage

// [eiv_top.sv]
// Purpose: external pin request detection plus vector selection and entry
// Assumes: inputs synchronous to clock_in; pin is active low
// Notes: vector table is held in a small writable array
`timescale 1ns/1ps
module eiv_top (
    input wire logic clock_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // request pin and stop mode
    input wire logic pin_n_in,
    input wire logic stop_mode_in,
    output logic wake_out,
    output logic pullup_enable_out,
    output logic branch_if_pin_high_out,
    output logic branch_if_pin_low_out,
    // other vector sources, one flag/enable pair each
    input wire logic [31:0] vec_flag_in,
    input wire logic [31:0] vec_enable_in,
    // reset sources sharing vector 0
    input wire logic [5:0] reset_src_in,
    input wire logic watchdog_enable_in,
    input wire logic low_voltage_reset_enable_in,
    input wire logic reset_pin_enable_in,
    // cpu side
    input wire logic cpu_instr_done_in,
    input wire logic [15:0] cpu_pc_in,
    input wire logic [7:0] cpu_x_in,
    input wire logic [7:0] cpu_a_in,
    input wire logic [7:0] cpu_ccr_in,
    output logic stack_push_out,
    output logic [7:0] stack_data_out,
    output logic vector_fetch_out,
    output logic [4:0] vector_num_out,
    output logic [15:0] handler_addr_out,
    output logic global_mask_out,
    output logic irq_out
);
    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        logic pe;
        logic mode;
        logic pdd;
        logic ie;
        logic flag;
        logic pin_prev;
        logic gmask;
        logic [eiv_pkg::EIV_IST_W-1:0] istat;
        logic [eiv_pkg::EIV_IST_W-1:0] imask;
        logic [7:0] rdata;
        eiv_pkg::eiv_seq_e seq;
        logic [2:0] step;
        logic [4:0] vnum;
        logic push;
        logic [7:0] sdata;
        logic fetch;
        logic [15:0] haddr;
    } eiv_state_s;

    eiv_state_s s_q;
    eiv_state_s s_d;
    logic [7:0] vec_mem [0:63];
    logic pin_low;
    logic edge_evt;
    logic level_evt;
    logic pin_evt;
    logic [31:0] req;
    logic req_any;
    logic [4:0] req_num;
    logic [5:0] rst_en;
    logic vec_wr;
    logic [5:0] vec_idx;
    logic [5:0] hi_idx;

    // ***************************************************
    // pin detection
    // ***************************************************
    assign pin_low = ~pin_n_in;
    // falling edge seen against the previous sample
    assign edge_evt = s_q.pe & s_q.pin_prev & pin_low;
    // mode 1 keeps raising events while the pin is low
    assign level_evt = s_q.pe & s_q.mode & pin_low;
    assign pin_evt = edge_evt | level_evt;

    // async path: no clock is needed when the system clocks are off
    assign wake_out = stop_mode_in & s_q.pe & pin_low;
    assign pullup_enable_out = s_q.pe & ~s_q.pdd;
    assign branch_if_pin_high_out = s_q.pe & pin_n_in;
    assign branch_if_pin_low_out = s_q.pe & pin_low;

    // ***************************************************
    // request collection and priority
    // ***************************************************
    // watchdog, low voltage, reset pin gated; opcode, address, por not
    assign rst_en = {3'h7, reset_pin_enable_in,
                     low_voltage_reset_enable_in, watchdog_enable_in};

    genvar gi;
    generate
        for (gi = 0; gi < eiv_pkg::EIV_NVEC; gi = gi + 1) begin : g_req
            if (gi == eiv_pkg::EIV_VEC_RESET) begin : g_rst
                // any enabled reset pair requests the shared slot
                assign req[gi] = |(reset_src_in & rst_en);
            end else if (gi == eiv_pkg::EIV_VEC_PIN) begin : g_pin
                assign req[gi] = s_q.flag & s_q.ie;
            end else if (eiv_pkg::EIV_VEC_USED[gi]) begin : g_src
                assign req[gi] = vec_flag_in[gi] & vec_enable_in[gi];
            end else begin : g_none
                assign req[gi] = 1'b0;
            end
        end
    endgenerate

    // scan from the top down so the lowest number is kept last
    always_comb begin
        req_num = 5'h00;
        for (int i = eiv_pkg::EIV_NVEC - 1; i >= 0; i--) begin
            if (req[i]) begin
                req_num = 5'(i);
            end
        end
    end
    assign req_any = |req;

    // entry 0 sits at the top: high byte of entry n at 62 - 2n
    assign hi_idx = 6'(62 - 2 * int'(s_q.vnum));

    // ***************************************************
    // vector table storage
    // ***************************************************
    assign vec_wr = wr_in & (addr_in >= eiv_pkg::EIV_ADDR_VEC_BASE);
    assign vec_idx = addr_in[5:0];

    // table is plain storage, not reset, loaded by software
    always_ff @(posedge clock_in) begin
        if (vec_wr) begin
            vec_mem[vec_idx] <= wdata_in;
        end
    end

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        logic ack_clr;
        logic [eiv_pkg::EIV_IST_W-1:0] ev;
        logic [eiv_pkg::EIV_IST_W-1:0] w1c;
        ack_clr = 1'b0;
        ev = '0;
        w1c = '0;
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.fetch = 1'b0;
        s_d.pin_prev = pin_n_in;

        // register writes
        if (wr_in) begin
            case (addr_in)
                eiv_pkg::EIV_ADDR_CTRL: begin
                    s_d.mode = wdata_in[eiv_pkg::EIV_BIT_MODE];
                    s_d.ie = wdata_in[eiv_pkg::EIV_BIT_IE];
                    s_d.pe = wdata_in[eiv_pkg::EIV_BIT_PE];
                    s_d.pdd = wdata_in[eiv_pkg::EIV_BIT_PDD];
                    ack_clr = wdata_in[eiv_pkg::EIV_BIT_ACK];
                end
                eiv_pkg::EIV_ADDR_GMASK: begin
                    s_d.gmask = wdata_in[0];
                end
                eiv_pkg::EIV_ADDR_ISTAT: begin
                    w1c = wdata_in[eiv_pkg::EIV_IST_W-1:0];
                end
                eiv_pkg::EIV_ADDR_IMASK: begin
                    s_d.imask = wdata_in[eiv_pkg::EIV_IST_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // a new event beats a clear in the same cycle
        s_d.flag = pin_evt | (s_q.flag & ~ack_clr);

        // entry sequencer
        case (s_q.seq)
            eiv_pkg::EIV_IDLE: begin
                // wait for an instruction boundary with the mask open
                if (req_any && !s_q.gmask && cpu_instr_done_in) begin
                    s_d.seq = eiv_pkg::EIV_PUSH;
                    s_d.vnum = req_num;
                    s_d.step = 3'h0;
                end
            end
            eiv_pkg::EIV_PUSH: begin
                // order: pc low, pc high, index, accumulator, codes
                s_d.push = 1'b1;
                case (s_q.step)
                    3'h0: s_d.sdata = cpu_pc_in[7:0];
                    3'h1: s_d.sdata = cpu_pc_in[15:8];
                    3'h2: s_d.sdata = cpu_x_in;
                    3'h3: s_d.sdata = cpu_a_in;
                    default: s_d.sdata = cpu_ccr_in;
                endcase
                s_d.step = s_q.step + 3'h1;
                if (s_q.step == eiv_pkg::EIV_PUSH_LAST) begin
                    s_d.gmask = 1'b1;
                    s_d.seq = eiv_pkg::EIV_FETCH;
                end
            end
            eiv_pkg::EIV_FETCH: begin
                s_d.fetch = 1'b1;
                s_d.haddr = {vec_mem[hi_idx], vec_mem[hi_idx + 6'h01]};
                ev[eiv_pkg::EIV_IST_TAKEN] = 1'b1;
                s_d.seq = eiv_pkg::EIV_IDLE;
            end
            default: begin
                s_d.seq = eiv_pkg::EIV_IDLE;
            end
        endcase

        // sticky status, set wins over write-one-to-clear
        ev[eiv_pkg::EIV_IST_PIN] = pin_evt;
        ev[eiv_pkg::EIV_IST_WAKE] = wake_out;
        s_d.istat = ev | (s_q.istat & ~w1c);

        // read data lands one cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd_in) begin
            if (addr_in >= eiv_pkg::EIV_ADDR_VEC_BASE) begin
                s_d.rdata = vec_mem[vec_idx];
            end else begin
                case (addr_in)
                    eiv_pkg::EIV_ADDR_CTRL: begin
                        // ack and reserved bits read as zero
                        s_d.rdata[eiv_pkg::EIV_BIT_MODE] = s_q.mode;
                        s_d.rdata[eiv_pkg::EIV_BIT_IE] = s_q.ie;
                        s_d.rdata[eiv_pkg::EIV_BIT_FLAG] = s_q.flag;
                        s_d.rdata[eiv_pkg::EIV_BIT_PE] = s_q.pe;
                        s_d.rdata[eiv_pkg::EIV_BIT_PDD] = s_q.pdd;
                    end
                    eiv_pkg::EIV_ADDR_GMASK: s_d.rdata[0] = s_q.gmask;
                    eiv_pkg::EIV_ADDR_PEND: begin
                        s_d.rdata = {req_any, 2'b00, req_num};
                    end
                    eiv_pkg::EIV_ADDR_ISTAT: begin
                        s_d.rdata[eiv_pkg::EIV_IST_W-1:0] = s_q.istat;
                    end
                    eiv_pkg::EIV_ADDR_IMASK: begin
                        s_d.rdata[eiv_pkg::EIV_IST_W-1:0] = s_q.imask;
                    end
                    default: s_d.rdata = 8'h00;
                endcase
            end
        end
    end

    // ***************************************************
    // state register
    // ***************************************************
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.gmask <= eiv_pkg::EIV_RST_GMASK;
            s_q.pin_prev <= eiv_pkg::EIV_RST_PIN_PREV;
            s_q.seq <= eiv_pkg::EIV_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    assign rdata_out = s_q.rdata;
    assign stack_push_out = s_q.push;
    assign stack_data_out = s_q.sdata;
    assign vector_fetch_out = s_q.fetch;
    assign vector_num_out = s_q.vnum;
    assign handler_addr_out = s_q.haddr;
    assign global_mask_out = s_q.gmask;
    // level output, high while any unmasked status bit stands
    assign irq_out = |(s_q.istat & s_q.imask);
endmodule

// [eiv_pin_model.sv]
// Purpose: outside device that drives the active-low request pin
// Assumes: the line carries a pull-up, internal or external
// Notes: a released line reads high, never the last driven value
`timescale 1ns/1ps
module eiv_pin_model (
    input wire logic assert_in,
    output logic pin_n_out
);
    // pull low to request, else let the pull-up win
    assign pin_n_out = assert_in ? 1'b0 : 1'b1;
endmodule

// [eiv_top_asserts.sv]
// Purpose: port-level checker for the pin request and vector block
// Assumes: one clock domain, asynchronous active-high reset
// Notes: cpu register inputs must stay steady during an entry
`timescale 1ns/1ps
module eiv_top_asserts (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic pin_n_in,
    input wire logic stop_mode_in,
    input wire logic wake_out,
    input wire logic pullup_enable_out,
    input wire logic branch_if_pin_high_out,
    input wire logic branch_if_pin_low_out,
    input wire logic [31:0] vec_flag_in,
    input wire logic [31:0] vec_enable_in,
    input wire logic cpu_instr_done_in,
    input wire logic [15:0] cpu_pc_in,
    input wire logic [7:0] cpu_x_in,
    input wire logic [7:0] cpu_a_in,
    input wire logic [7:0] cpu_ccr_in,
    input wire logic stack_push_out,
    input wire logic [7:0] stack_data_out,
    input wire logic vector_fetch_out,
    input wire logic [4:0] vector_num_out,
    input wire logic global_mask_out
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    logic [31:0] req_w;
    logic idle_w;
    logic take_w;
    // vectors 0 and 2 come from inside, so their port bits are dropped
    assign req_w = vec_flag_in & vec_enable_in & eiv_pkg::EIV_VEC_USED
        & 32'hFFFF_FFFA;
    assign idle_w = !stack_push_out && !vector_fetch_out;
    // an open request at an instruction boundary with the mask clear
    assign take_w = cpu_instr_done_in && !global_mask_out
        && req_w != 32'h0 && idle_w;
    property p_wake;
        wake_out |-> stop_mode_in && !pin_n_in;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without cause");
    property p_branch;
        branch_if_pin_low_out |-> !pin_n_in && !branch_if_pin_high_out;
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch level bad");
    property p_mask_rst;
        $fell(rst_in) |-> global_mask_out;
    endproperty
    a_mask_rst: assert property (p_mask_rst)
        else $error("mask clear");
    property p_push5;
        $rose(stack_push_out) |-> stack_push_out [*5] ##1
            (!stack_push_out && vector_fetch_out);
    endproperty
    a_push5: assert property (p_push5)
        else $error("push count");
    property p_order;
        $rose(stack_push_out) |-> stack_data_out == cpu_pc_in[7:0] ##1
            stack_data_out == cpu_pc_in[15:8] ##1 stack_data_out == cpu_x_in
            ##1 stack_data_out == cpu_a_in ##1 stack_data_out == cpu_ccr_in;
    endproperty
    a_order: assert property (p_order)
        else $error("push order");
    property p_mask_set;
        $rose(stack_push_out) |-> !global_mask_out [*4] ##1
            global_mask_out [*2];
    endproperty
    a_mask_set: assert property (p_mask_set)
        else $error("mask set");
    // the sequencer spends one quiet cycle leaving idle, so the first
    // byte shows two edges after the take; a take already seen is skipped
    property p_take;
        take_w && !$past(take_w) |-> ##2 $rose(stack_push_out);
    endproperty
    a_take: assert property (p_take)
        else $error("request not taken");
    property p_used;
        vector_fetch_out |-> eiv_pkg::EIV_VEC_USED[vector_num_out];
    endproperty
    a_used: assert property (p_used)
        else $error("unused vector");
    property p_pull;
        !$past(wr_in) |-> $stable(pullup_enable_out);
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull moved");
    property p_ack;
        $past(rd_in) && $past(addr_in) == eiv_pkg::EIV_ADDR_CTRL
            |-> !rdata_out[eiv_pkg::EIV_BIT_ACK];
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack reads one");
    c_entry: cover property (vector_fetch_out);
    c_wake: cover property (wake_out);
    c_low: cover property (branch_if_pin_low_out);
endmodule
bind eiv_top eiv_top_asserts eiv_top_asserts_i (.*);

// [tb_eiv_top.sv]
// Purpose: self-checking bench for the pin request and vector block
// Assumes: pin driven by the partner model, cpu registers held steady
// Notes: a set mask bit lets its status bit drive the interrupt output
`timescale 1ns/1ps
module tb_eiv_top;
    logic clock_in, rst_in, wr_in, rd_in, pin_n_in, stop_mode_in, pin_low;
    logic watchdog_enable_in, low_voltage_reset_enable_in;
    logic reset_pin_enable_in, cpu_instr_done_in, wake_out, irq_out;
    logic pullup_enable_out, branch_if_pin_high_out, branch_if_pin_low_out;
    logic stack_push_out, vector_fetch_out, global_mask_out;
    logic [7:0] addr_in, wdata_in, rdata_out, cpu_x_in, cpu_a_in;
    logic [7:0] cpu_ccr_in, stack_data_out;
    logic [31:0] vec_flag_in, vec_enable_in;
    logic [5:0] reset_src_in;
    logic [15:0] cpu_pc_in, handler_addr_out;
    logic [4:0] vector_num_out;
    int n_fail, checked;
    localparam logic [7:0] CT = eiv_pkg::EIV_ADDR_CTRL;
    localparam logic [7:0] PD = eiv_pkg::EIV_ADDR_PEND;
    localparam logic [7:0] ST = eiv_pkg::EIV_ADDR_ISTAT;
    localparam logic [7:0] IM = eiv_pkg::EIV_ADDR_IMASK;
    eiv_top eiv_top_i (.*);
    eiv_pin_model eiv_pin_model_i (.assert_in(pin_low), .pin_n_out(pin_n_in));
    // ****************************************
    // helpers
    // ****************************************
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: bit %b", $time, got);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe, so look just then
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 chk8(rdata_out, exp);
    endtask
    task automatic pin(input logic v);
        @(posedge clock_in);
        pin_low <= v;
        tick(3);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_pin;
        chk1(global_mask_out, 1'b1);
        rdc(eiv_pkg::EIV_ADDR_GMASK, 8'h01);
        pin(1'b1);
        rdc(CT, 8'h00);
        chk1(branch_if_pin_low_out, 1'b0);
        pin(1'b0);
        wr(CT, 8'h10);
        tick(0);
        chk1(pullup_enable_out, 1'b1);
        chk1(branch_if_pin_high_out, 1'b1);
        wr(CT, 8'h50);
        tick(0);
        chk1(pullup_enable_out, 1'b0);
        wr(CT, 8'h12);
        pin(1'b1);
        chk1(branch_if_pin_low_out, 1'b1);
        chk1(branch_if_pin_high_out, 1'b0);
        rdc(CT, 8'h1A);
        rdc(PD, 8'h82);
        wr(CT, 8'h10);
        rdc(CT, 8'h18);
        rdc(PD, 8'h00);
        wr(CT, 8'h14);
        rdc(CT, 8'h10);
        pin(1'b0);
        rdc(ST, 8'h01);
        wr(IM, 8'h07);
        tick(0);
        chk1(irq_out, 1'b1);
        wr(IM, 8'h00);
        tick(0);
        chk1(irq_out, 1'b0);
        wr(ST, 8'h07);
        rdc(ST, 8'h00);
        chk1(irq_out, 1'b0);
    endtask
    task automatic t_level;
        wr(CT, 8'h11);
        pin(1'b1);
        wr(CT, 8'h15);
        rdc(CT, 8'h19);
        pin(1'b0);
        wr(CT, 8'h15);
        rdc(CT, 8'h11);
        stop_mode_in <= 1'b1;
        pin(1'b1);
        chk1(wake_out, 1'b1);
        wr(CT, 8'h00);
        tick(0);
        chk1(wake_out, 1'b0);
        stop_mode_in <= 1'b0;
        pin(1'b0);
    endtask
    task automatic t_vec;
        int n_push;
        logic [39:0] frame;
        n_push = 0;
        // stacking order: pc low, pc high, index, accumulator, codes
        frame = {cpu_ccr_in, cpu_a_in, cpu_x_in, cpu_pc_in};
        wr(8'hF4, 8'hA5);
        wr(8'hF5, 8'h05);
        rdc(8'hF4, 8'hA5);
        vec_enable_in <= 32'h0100_0020;
        vec_flag_in <= 32'h0100_1000;
        rdc(PD, 8'h00);
        vec_enable_in <= 32'h0100_1020;
        vec_flag_in <= 32'h0100_1020;
        rdc(PD, 8'h85);
        for (int i = 0; i < 6; i++) begin
            reset_src_in <= 6'h01 << i;
            rdc(PD, 8'h80);
        end
        watchdog_enable_in <= 1'b0;
        reset_src_in <= 6'h01;
        rdc(PD, 8'h85);
        reset_src_in <= 6'h00;
        wr(eiv_pkg::EIV_ADDR_GMASK, 8'h00);
        for (int i = 0; i < 20 && vector_fetch_out !== 1'b1; i++) begin
            tick(1);
            if (stack_push_out === 1'b1 && n_push < 5) begin
                chk8(stack_data_out, frame[8*n_push +: 8]);
                n_push++;
            end
        end
        chk8(8'(n_push), 8'h05);
        chk1(vector_fetch_out, 1'b1);
        chk8({3'h0, vector_num_out}, 8'h05);
        chk8(handler_addr_out[15:8], 8'hA5);
        chk8(handler_addr_out[7:0], 8'h05);
        chk1(global_mask_out, 1'b1);
        vec_flag_in <= 32'h0;
        // pin event and wake from the level scenario, entry taken now
        rdc(ST, 8'h07);
    endtask
    // reset for eight cycles, then run every scenario once
    initial begin
        {rst_in, watchdog_enable_in, reset_pin_enable_in} = 3'h7;
        {low_voltage_reset_enable_in, cpu_instr_done_in} = 2'h3;
        {wr_in, rd_in, pin_low, stop_mode_in} = 4'h0;
        {addr_in, wdata_in, reset_src_in} = '0;
        {vec_flag_in, vec_enable_in} = '0;
        {cpu_pc_in, cpu_x_in, cpu_a_in, cpu_ccr_in} = 40'h1234_5678_9A;
        n_fail = 0;
        checked = 0;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        t_pin();
        t_level();
        t_vec();
        tick(4);
        test_done();
    end
endmodule
